/* spm_consts.vh */
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// character size and index of the last edge of a character
`define SPM_CHAR_BITS 8
`define SPM_LAST_EDGE 5'h0f

// master half sck period in mclk cycles, at least three:
// synced miso lags the drive edge by two cycles
`define SPM_SCK_HALF_CYC 4'h4

// receive fifo shape
`define SPM_FIFO_DEPTH 8
`define SPM_FIFO_AW 3

// reset values
`define SPM_RST_CHAR 8'h00
`define SPM_RST_FLAG 1'b0

`endif

/* spm_sync.v */
module spm_sync #(
  parameter W = 4
) (
  input wire mclk,
  input wire sys_rst,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // first stage is read by the second stage only
  always @(posedge mclk) begin
    if (sys_rst) begin
      meta_ff <= {W{1'b1}};
      sync_ff <= {W{1'b1}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

/* spm_fifo.v */
module spm_fifo #(
  parameter W = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk,
  input wire sys_rst,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_ff;
  reg [AW-1:0] rptr_ff;
  reg [AW:0] cnt_ff;
  reg [W-1:0] out_data_ff;
  reg out_valid_ff;

  wire push;
  wire pop;

  assign in_ready = (cnt_ff != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  // output register refills whenever empty or drained
  assign pop = (cnt_ff != {(AW+1){1'b0}}) && (!out_valid_ff || out_ready);

  always @(posedge mclk) begin
    if (push) begin
      mem[wptr_ff] <= in_data;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      wptr_ff <= {AW{1'b0}};
      rptr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      out_data_ff <= {W{1'b0}};
      out_valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
        out_data_ff <= mem[rptr_ff];
        out_valid_ff <= 1'b1;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  assign out_data = out_data_ff;
  assign out_valid = out_valid_ff;

endmodule

/* spm_port.v */
// Summary of operation
// - master sck at most half mclk rate
// - eight-bit characters, most significant bit first
// - master select high master, low slave
// - master drives sck, slave receives it
// - slave active only while select is low
// - shift register copied into read buffer
// - overrun only if buffer still unread
// - busy write dropped, collision flag set
// - last bit sets complete flag, interrupt
// - select low in master gives mode fault
// - polarity and phase match both ends
// - master data leads sampling edge half-cycle
// - collision detected in master and slave
`include "spm_consts.vh"

module spm_port (
  input wire mclk,
  input wire sys_rst,
  input wire master_select_bit,
  input wire clk_pol,
  input wire clk_pha,
  input wire transfer_interrupt_enable,
  input wire [7:0] tx_data,
  input wire tx_wr,
  output wire [7:0] rx_data,
  output wire rx_valid,
  input wire rx_ready,
  input wire clr_transfer_complete,
  input wire clr_write_collision,
  input wire clr_mode_fault,
  input wire clr_overrun,
  output wire transfer_complete_flag,
  output wire write_collision_flag,
  output wire mode_fault_flag,
  output wire overrun_flag,
  output wire busy,
  output wire irq,
  input wire sck_in,
  output wire sck_out,
  output wire sck_oe,
  input wire mosi_in,
  output wire mosi_out,
  output wire mosi_oe,
  input wire miso_in,
  output wire miso_out,
  output wire miso_oe,
  input wire ss_n_in
);

  localparam ST_IDLE = 2'h0;
  localparam ST_MASTER = 2'h1;
  localparam ST_SLAVE = 2'h2;

  reg [1:0] st_ff;
  reg [3:0] half_cnt_ff;
  reg [4:0] edge_cnt_ff;
  reg sck_ff;
  reg sck_prev_ff;
  reg [7:0] shift_ff;
  reg out_ff;
  reg [7:0] rx_buf_ff;
  reg rx_buf_vld_ff;
  reg tc_ff;
  reg write_collision_flag_ff;
  reg modf_ff;
  reg ovr_ff;
  reg irq_ff;
  reg busy_ff;
  reg sck_oe_ff;
  reg mosi_oe_ff;
  reg miso_oe_ff;

  wire [3:0] syn;
  wire ss_n_s;
  wire sck_s;
  wire mosi_s;
  wire miso_s;
  wire fifo_in_ready;

  // every pin passes two flip-flops before use
  spm_sync #(
    .W(4)
  ) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din({ss_n_in, sck_in, mosi_in, miso_in}),
    .dout(syn)
  );

  assign ss_n_s = syn[3];
  assign sck_s = syn[2];
  assign mosi_s = syn[1];
  assign miso_s = syn[0];

  // event decode for both roles
  reg tick;
  reg lead_ev;
  reg trail_ev;
  reg sample_ev;
  reg drive_ev;
  reg in_bit;
  reg last_ev;
  reg tx_ok;
  reg done;
  reg [7:0] done_char;
  reg sck_edge;

  always @* begin
    tick = 1'b0;
    lead_ev = 1'b0;
    trail_ev = 1'b0;
    sck_edge = (sck_s != sck_prev_ff);
    if (st_ff == ST_MASTER) begin
      // a toggle never comes faster than every fourth cycle
      tick = (half_cnt_ff == `SPM_SCK_HALF_CYC - 4'h1);
      lead_ev = tick && !edge_cnt_ff[0];
      trail_ev = tick && edge_cnt_ff[0];
    end else if (st_ff == ST_SLAVE) begin
      // slave edges come from the sampled line
      lead_ev = sck_edge && (sck_s != clk_pol);
      trail_ev = sck_edge && (sck_s == clk_pol);
    end
    // phase picks the sampling edge, the other edge drives
    sample_ev = clk_pha ? trail_ev : lead_ev;
    drive_ev = clk_pha ? lead_ev : trail_ev;
    in_bit = (st_ff == ST_MASTER) ? miso_s : mosi_s;
    last_ev = (lead_ev || trail_ev) && (edge_cnt_ff == `SPM_LAST_EDGE);
    done = last_ev;
    done_char = sample_ev ? {shift_ff[6:0], in_bit} : shift_ff;
    // shift register is the only transmit storage
    tx_ok = 1'b0;
    if (st_ff == ST_IDLE) begin
      tx_ok = master_select_bit ? ss_n_s : 1'b1;
    end else if (st_ff == ST_SLAVE) begin
      // phase one slave may reload between characters
      tx_ok = clk_pha && (edge_cnt_ff == 5'h00) && !sck_edge;
    end
  end

  // transfer engine
  always @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= ST_IDLE;
      half_cnt_ff <= 4'h0;
      edge_cnt_ff <= 5'h00;
      sck_ff <= 1'b0;
      shift_ff <= `SPM_RST_CHAR;
      out_ff <= 1'b0;
    end else begin
      if (tx_wr && tx_ok) begin
        shift_ff <= tx_data;
        out_ff <= tx_data[`SPM_CHAR_BITS-1];
      end else if (sample_ev) begin
        shift_ff <= {shift_ff[6:0], in_bit};
      end
      if (drive_ev && !(tx_wr && tx_ok)) begin
        // leading bit leaves first, one edge before sampling
        out_ff <= sample_ev ? shift_ff[6] : shift_ff[7];
      end
      case (st_ff)
        ST_IDLE: begin
          sck_ff <= clk_pol;
          half_cnt_ff <= 4'h0;
          edge_cnt_ff <= 5'h00;
          if (master_select_bit) begin
            if (tx_wr && tx_ok) begin
              st_ff <= ST_MASTER;
            end
          end else if (!ss_n_s) begin
            st_ff <= ST_SLAVE;
            if (!clk_pha && !tx_wr) begin
              // phase zero: first bit must stand before first edge
              out_ff <= shift_ff[7];
            end
          end
        end
        ST_MASTER: begin
          if (!ss_n_s || !master_select_bit) begin
            // select pulled low: abandon the character
            st_ff <= ST_IDLE;
            sck_ff <= clk_pol;
          end else if (tick) begin
            half_cnt_ff <= 4'h0;
            sck_ff <= ~sck_ff;
            edge_cnt_ff <= edge_cnt_ff + 5'h01;
            if (last_ev) begin
              st_ff <= ST_IDLE;
            end
          end else begin
            half_cnt_ff <= half_cnt_ff + 4'h1;
          end
        end
        ST_SLAVE: begin
          if (ss_n_s || master_select_bit) begin
            // deselect drops a partial character
            st_ff <= ST_IDLE;
            edge_cnt_ff <= 5'h00;
          end else if (lead_ev || trail_ev) begin
            if (last_ev) begin
              edge_cnt_ff <= 5'h00;
            end else begin
              edge_cnt_ff <= edge_cnt_ff + 5'h01;
            end
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // slave edge detector reads the second sync stage only
  always @(posedge mclk) begin
    if (sys_rst) begin
      // same level as the sync reset, so no false edge
      sck_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff <= sck_s;
    end
  end

  // read buffer between shift register and fifo
  wire rx_move;
  assign rx_move = rx_buf_vld_ff && fifo_in_ready;

  always @(posedge mclk) begin
    if (sys_rst) begin
      rx_buf_ff <= `SPM_RST_CHAR;
      rx_buf_vld_ff <= 1'b0;
    end else begin
      if (done && (!rx_buf_vld_ff || rx_move)) begin
        rx_buf_ff <= done_char;
        rx_buf_vld_ff <= 1'b1;
      end else if (rx_move) begin
        rx_buf_vld_ff <= 1'b0;
      end
    end
  end

  spm_fifo #(
    .W(`SPM_CHAR_BITS),
    .DEPTH(`SPM_FIFO_DEPTH),
    .AW(`SPM_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_data(rx_buf_ff),
    .in_valid(rx_buf_vld_ff),
    .in_ready(fifo_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // sticky flags, a set wins over a clear in the same cycle
  wire nxt_tc;
  wire write_collision_flag_set;
  wire modf_set;
  wire ovr_set;

  assign nxt_tc = done || (tc_ff && !clr_transfer_complete);
  assign write_collision_flag_set = tx_wr && !tx_ok;
  assign modf_set = master_select_bit && !ss_n_s;
  // older character kept, newer one lost
  assign ovr_set = done && rx_buf_vld_ff && !fifo_in_ready;

  always @(posedge mclk) begin
    if (sys_rst) begin
      tc_ff <= `SPM_RST_FLAG;
      write_collision_flag_ff <= `SPM_RST_FLAG;
      modf_ff <= `SPM_RST_FLAG;
      ovr_ff <= `SPM_RST_FLAG;
      irq_ff <= 1'b0;
    end else begin
      tc_ff <= nxt_tc;
      write_collision_flag_ff <= write_collision_flag_set || (write_collision_flag_ff && !clr_write_collision);
      modf_ff <= modf_set || (modf_ff && !clr_mode_fault);
      ovr_ff <= ovr_set || (ovr_ff && !clr_overrun);
      irq_ff <= nxt_tc && transfer_interrupt_enable;
    end
  end

  // pin drivers follow role and select
  always @(posedge mclk) begin
    if (sys_rst) begin
      sck_oe_ff <= 1'b0;
      mosi_oe_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      // master backs off the bus once select goes low
      sck_oe_ff <= master_select_bit && ss_n_s;
      mosi_oe_ff <= master_select_bit && ss_n_s;
      miso_oe_ff <= !master_select_bit && !ss_n_s;
      busy_ff <= !tx_ok;
    end
  end

  assign sck_out = sck_ff;
  assign sck_oe = sck_oe_ff;
  assign mosi_out = out_ff;
  assign mosi_oe = mosi_oe_ff;
  assign miso_out = out_ff;
  assign miso_oe = miso_oe_ff;
  assign transfer_complete_flag = tc_ff;
  assign write_collision_flag = write_collision_flag_ff;
  assign mode_fault_flag = modf_ff;
  assign overrun_flag = ovr_ff;
  assign busy = busy_ff;
  assign irq = irq_ff;

endmodule

/* spm_port_assertions.sv */
module spm_port_assertions (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic master_select_bit,
  input wire logic clk_pol,
  input wire logic clk_pha,
  input wire logic transfer_interrupt_enable,
  input wire logic tx_wr,
  input wire logic transfer_complete_flag,
  input wire logic write_collision_flag,
  input wire logic mode_fault_flag,
  input wire logic overrun_flag,
  input wire logic busy,
  input wire logic irq,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_out,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_n_in
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  half_rate_a: assert property (
    sck_oe && $changed(sck_out) |=> $stable(sck_out))
    else $error("sck toggled twice in a row");
  idle_level_a: assert property (
    master_select_bit && sck_oe && !busy && $stable(clk_pol)
    |-> sck_out == clk_pol) else $error("bad sck idle level");
  data_lead_a: assert property (
    master_select_bit && mosi_oe && $changed(sck_out)
    && ((sck_out != clk_pol) != clk_pha)
    |-> $stable(mosi_out) && $past(mosi_out) == $past(mosi_out, 2))
    else $error("mosi moved near sample edge");
  run_len_a: assert property (
    master_select_bit && ss_n_in && tx_wr && !busy
    && !transfer_complete_flag
    |-> ##65 ($rose(transfer_complete_flag) || mode_fault_flag))
    else $error("transfer length wrong");
  collide_a: assert property (
    busy && tx_wr |=> write_collision_flag)
    else $error("collision not flagged");
  write_collision_flag_cause_a: assert property (
    $rose(write_collision_flag) |-> $past(tx_wr))
    else $error("collision flag without write");
  irq_gate_a: assert property (
    irq |-> transfer_complete_flag || $past(transfer_complete_flag))
    else $error("irq without flag");
  irq_rise_a: assert property (
    $rose(transfer_complete_flag) && transfer_interrupt_enable
    && $past(transfer_interrupt_enable) |-> ##[0:1] irq)
    else $error("irq missing");
  fault_sets_a: assert property (
    (master_select_bit && !ss_n_in) [*5] |-> mode_fault_flag)
    else $error("mode fault missing");
  fault_cause_a: assert property (
    $rose(mode_fault_flag) |-> $past(master_select_bit))
    else $error("mode fault in slave");
  pin_roles_a: assert property (
    $stable(master_select_bit) |-> (master_select_bit ? !miso_oe
    : !sck_oe && !mosi_oe)) else $error("pin driven in wrong role");
  slave_quiet_a: assert property (
    (!master_select_bit && ss_n_in) [*5] |-> !miso_oe)
    else $error("unselected slave drives miso");

  cover property ($rose(transfer_complete_flag) && master_select_bit);
  cover property ($rose(transfer_complete_flag) && !master_select_bit);
  cover property ($rose(mode_fault_flag));
  cover property ($rose(overrun_flag));
endmodule

bind spm_port spm_port_assertions u_chk (
  .mclk, .sys_rst, .master_select_bit, .clk_pol, .clk_pha,
  .transfer_interrupt_enable, .tx_wr, .transfer_complete_flag,
  .write_collision_flag, .mode_fault_flag, .overrun_flag, .busy, .irq,
  .sck_out, .sck_oe, .mosi_out, .mosi_oe, .miso_oe, .ss_n_in
);

/* spm_far.sv */
module spm_far (
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic pol,
  input wire logic pha,
  input wire logic sel,
  input wire logic [7:0] sdata,
  output logic [7:0] rdata,
  output logic far_sck,
  output logic far_mosi,
  output logic far_miso,
  output logic far_ss_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] o;
  initial begin
    rdata = 8'h00;
    far_sck = 1'h0;
    far_mosi = 1'h0;
    far_miso = 1'h0;
    far_ss_n = 1'h1;
  end
  // slave role; no pull on miso, so a released line flips
  always @(posedge sel) begin
    o = sdata;
    far_miso = sdata[7];
  end
  always @(negedge sel) far_miso = ~far_miso;
  always @(sck) begin
    if (sel && ((sck != pol) ^ pha)) begin
      rdata = {rdata[6:0], mosi};
    end else if (sel) begin
      if (!pha) o = o << 1;
      far_miso = o[7];
      if (pha) o = o << 1;
    end
  end
  // master role, 125 ns sck that stands still between characters
  task automatic xfer(input logic [7:0] tx);
    o = tx;
    far_sck = pol;
    #125;
    far_ss_n = 1'h0;
    if (!pha) far_mosi = o[7];
    #62.5;
    repeat (8) begin
      far_sck = ~pol;
      if (pha) far_mosi = o[7];
      else rdata = {rdata[6:0], miso};
      #62.5;
      far_sck = pol;
      if (pha) rdata = {rdata[6:0], miso};
      else far_mosi = o[6];
      o = o << 1;
      #62.5;
    end
    far_ss_n = 1'h1;
    far_mosi = ~far_mosi;
  endtask
endmodule

/* spm_port_tb.sv */
module spm_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, sys_rst = 1, master_select_bit = 1, clk_pol = 0;
  logic clk_pha = 0, transfer_interrupt_enable = 0, tx_wr = 0;
  logic rx_ready = 1, tb_ss_n = 1, sel = 0;
  logic [3:0] clr = 4'h0;
  logic [7:0] tx_data = 8'h00, sdata = 8'h00, rx_data, far_rx;
  logic rx_valid, transfer_complete_flag, write_collision_flag;
  logic mode_fault_flag, overrun_flag, busy, irq, sck_out, sck_oe;
  logic mosi_out, mosi_oe, miso_out, miso_oe;
  logic far_sck, far_mosi, far_miso, far_ss_n;
  logic [31:0] r = 32'hd63b57bc;
  logic [7:0] q[$];
  int mismatches = 0, compares = 0, cyc = 0;
  wire sck_in = sck_oe ? sck_out : far_sck;
  wire mosi_in = mosi_oe ? mosi_out : far_mosi;
  wire miso_in = miso_oe ? miso_out : far_miso;
  wire ss_n_in = far_ss_n & tb_ss_n;

  always #5 mclk = ~mclk;

  spm_port u_dut (
    .mclk, .sys_rst, .master_select_bit, .clk_pol, .clk_pha,
    .transfer_interrupt_enable, .tx_data, .tx_wr, .rx_data, .rx_valid,
    .rx_ready, .clr_transfer_complete(clr[0]),
    .clr_write_collision(clr[1]), .clr_mode_fault(clr[2]),
    .clr_overrun(clr[3]), .transfer_complete_flag, .write_collision_flag,
    .mode_fault_flag, .overrun_flag, .busy, .irq, .sck_in, .sck_out,
    .sck_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out,
    .miso_oe, .ss_n_in
  );
  spm_far u_far (
    .sck(sck_in), .mosi(mosi_in), .miso(miso_in), .pol(clk_pol),
    .pha(clk_pha), .sel, .sdata, .rdata(far_rx), .far_sck, .far_mosi,
    .far_miso, .far_ss_n
  );

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'h0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task check(input logic [7:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task wr(input logic [7:0] d);
    @(posedge mclk);
    tx_data <= d;
    tx_wr <= 1'h1;
    @(posedge mclk);
    tx_wr <= 1'h0;
  endtask

  task clear(input logic [3:0] m);
    @(posedge mclk);
    clr <= m;
    @(posedge mclk);
    clr <= 4'h0;
  endtask

  // master character with a write thrown in while it runs
  task mx;
    int n;
    r = lfsr(r);
    // idle sck takes a new polarity before the far end is selected
    tick(2);
    sdata <= r[15:8];
    sel <= 1'h1;
    wr(r[7:0]);
    tick(4);
    wr(~r[7:0]);
    n = 0;
    while (transfer_complete_flag !== 1'h1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    check(far_rx, r[7:0], "far rx");
    check(8'(irq), 8'(transfer_interrupt_enable), "irq");
    check(8'(write_collision_flag), 8'h1, "collision");
    q.push_back(r[15:8]);
    sel <= 1'h0;
    clear(4'h3);
  endtask

  // results leave in order; a missing note is a mismatch too
  always @(posedge mclk)
    if (!sys_rst && rx_valid === 1'h1 && rx_ready)
      check(rx_data, q.size() ? q.pop_front() : 8'hxx, "rx");

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      report_and_stop;
    end
  end

  initial begin
    tick(6);
    sys_rst <= 1'h0;
    tick(3);
    for (int m = 0; m < 4; m++) begin
      clk_pol <= m[1];
      clk_pha <= m[0];
      transfer_interrupt_enable <= m[0];
      mx();
    end
    $display("master modes done");
    master_select_bit <= 1'h0;
    for (int m = 0; m < 4; m++) begin
      clk_pol <= m[0];
      clk_pha <= m[1];
      r = lfsr(r);
      wr(r[7:0]);
      q.push_back(r[15:8]);
      u_far.xfer(r[15:8]);
      tick(8);
      @(negedge mclk);
      check(far_rx, r[7:0], "slave tx");
      check(8'(transfer_complete_flag), 8'h1, "slave done");
      clear(4'h1);
    end
    $display("slave modes done");
    master_select_bit <= 1'h1;
    tick(3);
    wr(8'h5a);
    tick(8);
    tb_ss_n <= 1'h0;
    tick(6);
    @(negedge mclk);
    check(8'(mode_fault_flag), 8'h1, "fault");
    check(8'(sck_oe), 8'h0, "sck drive");
    tb_ss_n <= 1'h1;
    tick(70);
    check(8'(transfer_complete_flag), 8'h0, "aborted");
    clear(4'h7);
    $display("mode fault done");
    // stall the reader until the buffer refuses; the late char is lost
    rx_ready <= 1'h0;
    for (int k = 0; k < 12 && overrun_flag !== 1'h1; k++) begin
      mx();
      @(negedge mclk);
      if (overrun_flag === 1'h1) void'(q.pop_back());
    end
    check(8'(overrun_flag), 8'h1, "overrun");
    @(posedge mclk);
    rx_ready <= 1'h1;
    tick(30);
    check(8'(q.size()), 8'h0, "drained");
    clear(4'h8);
    $display("buffer done");
    report_and_stop;
  end
endmodule
